//--- verilog/adf_filter.sv
// auxiliary converter control registers, sinc3 and sinc1 decimation, calibration
`timescale 1ns/1ps

// Behaviour
// - take one modulator bit every 144 converter clocks
// - each conversion result is a 24-bit word from the filtered stream
// - first stage is sinc3 decimating by 64, 128 or 512
// - second stage is fed by first stage output at 100 SPS
// - second stage is sinc1 averaging ten inputs for 10 SPS
// - rates 800, 400, 100 bypass second stage and output first stage result
// - rate code 00 10SPS default, 01 100, 10 400, 11 800
// - total decimation is first ratio times second ratio, one when bypassed
// - all rates scale with the converter clock, nominal 7.3728 MHz
// - gain code 000..111 selects gain 1 to 128, doubling per step
// - gains 1, 2, 4 bypass the amplifier
// - input select register at 16h holds positive and negative four-bit selects
// - reference chooses internal, supply, or one of three external pin pairs
// - each result is corrected by 16-bit offset and 16-bit full-scale values
// - begin opcode 0Ch/0Dh starts continuous conversions, halt 0Eh/0Fh stops
module adf_filter
  import adf_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_MOD_BIT,
  input  wire logic        I_CMD_VALID,
  input  wire logic [7:0]  I_CMD,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  output logic      [23:0] O_RESULT,
  output logic             O_RESULT_VALID,
  output logic      [3:0]  O_POS_SEL,
  output logic      [3:0]  O_NEG_SEL,
  output logic      [2:0]  O_GAIN_CODE,
  output logic             O_PGA_BYPASS,
  output logic      [2:0]  O_REF_SEL,
  output logic      [1:0]  O_RATE_CODE,
  output logic             O_RUNNING
);
  function automatic logic [8:0] adf_dec_last(input logic [1:0] rate);
    case (rate)
      RATE_400: adf_dec_last = DEC_128_LAST;
      RATE_800: adf_dec_last = DEC_64_LAST;
      default:  adf_dec_last = DEC_512_LAST;
    endcase
  endfunction : adf_dec_last
  function automatic logic [23:0] adf_sat(input logic signed [41:0] v);
    if ((&v[41:23]) | ~(|v[41:23])) begin
      adf_sat = v[23:0];
    end else if (v[41]) begin
      adf_sat = 24'h80_0000;
    end else begin
      adf_sat = 24'h7f_ffff;
    end
  endfunction : adf_sat
  logic        [7:0]  cfg_q;
  logic        [7:0]  mux_q;
  logic        [15:0] ofs_q;
  logic        [15:0] fsc_q;
  logic        [7:0]  rdata_q;
  logic               bypass_q;
  adf_state_t         state_q;
  logic               running_q;
  logic        [1:0]  drop_q;
  logic               mod_s1_q, mod_s2_q;
  logic        [7:0]  div_q;
  logic               mod_stb_q, cic_stb_q, s1_stb_q;
  logic        [8:0]  dec_q;
  logic signed [31:0] i1_q, i2_q, i3_q;
  logic signed [31:0] d1_q, d2_q, d3_q;
  logic        [23:0] s1_q, raw_q, res_q;
  logic signed [27:0] acc_q;
  logic        [3:0]  avg_cnt_q;
  logic               raw_stb_q, res_stb_q;
  logic               wr_cfg, wr_mux;
  logic               cmd_begin, cmd_halt;
  logic               restart, clear_pipe;
  logic               take, dec_wrap;
  logic        [1:0]  rate;
  logic signed [31:0] x_in, c1, c2, c3;
  logic signed [41:0] c3_scaled;
  logic signed [27:0] sum10;
  logic signed [49:0] avg_prod;
  logic signed [24:0] cal_diff;
  logic signed [41:0] cal_prod;
  assign rate       = cfg_q[CFG_RATE_LSB +: 2];
  assign wr_cfg     = I_WR && (I_ADDR == ADDR_CFG);
  assign wr_mux     = I_WR && (I_ADDR == ADDR_MUX);
  assign cmd_begin  = I_CMD_VALID && (I_CMD[7:1] == CMD_BEGIN_HI);
  assign cmd_halt   = I_CMD_VALID && (I_CMD[7:1] == CMD_HALT_HI);
  // selection or rate change while running starts conversion afresh
  assign restart    = cmd_begin || ((state_q != ST_IDLE) && (wr_cfg || wr_mux));
  assign clear_pipe = (state_q == ST_IDLE) || restart || cmd_halt;
  // register writes
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      cfg_q    <= CFG_RESET;
      bypass_q <= 1'b1;
    end else if (wr_cfg) begin
      cfg_q[CFG_GAIN_LSB +: 3] <= I_WDATA[CFG_GAIN_LSB +: 3];
      cfg_q[CFG_RATE_LSB +: 2] <= I_WDATA[CFG_RATE_LSB +: 2];
      if (I_WDATA[CFG_REF_LSB +: 3] > REF_SUPPLY) begin
        cfg_q[CFG_REF_LSB +: 3] <= REF_INT;
      end else begin
        cfg_q[CFG_REF_LSB +: 3] <= I_WDATA[CFG_REF_LSB +: 3];
      end
      bypass_q <= I_WDATA[CFG_GAIN_LSB +: 3] < GAIN_PGA_MIN;
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      mux_q <= MUX_RESET;
    end else if (wr_mux) begin
      mux_q <= I_WDATA;
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ofs_q <= OFS_RESET;
      fsc_q <= FSC_RESET;
    end else if (I_WR) begin
      case (I_ADDR)
        ADDR_OFS_LO: ofs_q[7:0]  <= I_WDATA;
        ADDR_OFS_HI: ofs_q[15:8] <= I_WDATA;
        ADDR_FSC_LO: fsc_q[7:0]  <= I_WDATA;
        ADDR_FSC_HI: fsc_q[15:8] <= I_WDATA;
        default: ;
      endcase
    end
  end
  // register reads, data in the following cycle only
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rdata_q <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        ADDR_CFG:     rdata_q <= cfg_q;
        ADDR_MUX:     rdata_q <= mux_q;
        ADDR_OFS_LO:  rdata_q <= ofs_q[7:0];
        ADDR_OFS_HI:  rdata_q <= ofs_q[15:8];
        ADDR_FSC_LO:  rdata_q <= fsc_q[7:0];
        ADDR_FSC_HI:  rdata_q <= fsc_q[15:8];
        ADDR_RES_LO:  rdata_q <= res_q[7:0];
        ADDR_RES_MID: rdata_q <= res_q[15:8];
        ADDR_RES_HI:  rdata_q <= res_q[23:16];
        ADDR_STATUS:  rdata_q <= {7'h00, state_q != ST_IDLE};
        default:      rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  // conversion control
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      state_q   <= ST_IDLE;
      running_q <= 1'b0;
      drop_q    <= 2'h0;
    end else if (cmd_halt) begin
      state_q   <= ST_IDLE;
      running_q <= 1'b0;
    end else if (restart) begin
      state_q   <= ST_SETTLE;
      running_q <= 1'b1;
      drop_q    <= 2'h0;
    end else begin
      case (state_q)
        ST_SETTLE: begin
          if (s1_stb_q) begin
            drop_q <= drop_q + 2'h1;
            if (drop_q == SETTLE_LAST) begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN:  state_q <= ST_RUN;
        ST_IDLE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // modulator bit synchroniser
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      mod_s1_q <= 1'b0;
      mod_s2_q <= 1'b0;
    end else begin
      mod_s1_q <= I_MOD_BIT;
      mod_s2_q <= mod_s1_q;
    end
  end
  // modulator sample strobe, free running from the converter clock
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      div_q     <= 8'h00;
      mod_stb_q <= 1'b0;
    end else begin
      div_q     <= (div_q == MOD_DIV_LAST) ? 8'h00 : div_q + 8'h01;
      mod_stb_q <= (div_q == MOD_DIV_LAST);
    end
  end
  // sinc3 integrators on every modulator sample
  assign x_in     = mod_s2_q ? 32'h0000_0001 : 32'hffff_ffff;
  assign dec_wrap = mod_stb_q && (dec_q == adf_dec_last(rate));
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N || clear_pipe) begin
      i1_q      <= 32'h0000_0000;
      i2_q      <= 32'h0000_0000;
      i3_q      <= 32'h0000_0000;
      dec_q     <= 9'h000;
      cic_stb_q <= 1'b0;
    end else begin
      if (mod_stb_q) begin
        i1_q  <= i1_q + x_in;
        i2_q  <= i2_q + i1_q;
        i3_q  <= i3_q + i2_q;
        dec_q <= dec_wrap ? 9'h000 : dec_q + 9'h001;
      end
      cic_stb_q <= dec_wrap;
    end
  end
  // sinc3 combs at the decimated rate
  assign c1 = i3_q - d1_q;
  assign c2 = c1 - d2_q;
  assign c3 = c2 - d3_q;
  always_comb begin
    c3_scaled = {{10{c3[31]}}, c3};
    case (rate)
      RATE_400: c3_scaled = c3_scaled <<< SH_128_LEFT;
      RATE_800: c3_scaled = c3_scaled <<< SH_64_LEFT;
      default:  c3_scaled = c3_scaled >>> SH_512_RIGHT;
    endcase
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N || clear_pipe) begin
      d1_q     <= 32'h0000_0000;
      d2_q     <= 32'h0000_0000;
      d3_q     <= 32'h0000_0000;
      s1_q     <= 24'h00_0000;
      s1_stb_q <= 1'b0;
    end else begin
      s1_stb_q <= cic_stb_q;
      if (cic_stb_q) begin
        d1_q <= i3_q;
        d2_q <= c1;
        d3_q <= c2;
        s1_q <= adf_sat(c3_scaled);
      end
    end
  end
  // second stage: sinc1 over ten 100 SPS outputs, or bypass
  assign take     = s1_stb_q && (state_q == ST_RUN);
  assign sum10    = acc_q + {{4{s1_q[23]}}, s1_q};
  assign avg_prod = sum10 * $signed(AVG_RECIP);
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N || clear_pipe) begin
      acc_q     <= 28'h000_0000;
      avg_cnt_q <= 4'h0;
      raw_q     <= 24'h00_0000;
      raw_stb_q <= 1'b0;
    end else begin
      raw_stb_q <= 1'b0;
      if (take && (rate == RATE_10)) begin
        if (avg_cnt_q == AVG_LAST) begin
          raw_q     <= adf_sat(42'(avg_prod >>> AVG_SHIFT));
          raw_stb_q <= 1'b1;
          acc_q     <= 28'h000_0000;
          avg_cnt_q <= 4'h0;
        end else begin
          acc_q     <= sum10;
          avg_cnt_q <= avg_cnt_q + 4'h1;
        end
      end else if (take) begin
        raw_q     <= s1_q;
        raw_stb_q <= 1'b1;
      end
    end
  end
  // calibration: offset then full-scale
  assign cal_diff = {raw_q[23], raw_q} - 25'({{9{ofs_q[15]}}, ofs_q} <<< OFS_SHIFT);
  assign cal_prod = cal_diff * $signed({1'b0, fsc_q});
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      res_q     <= 24'h00_0000;
      res_stb_q <= 1'b0;
    end else begin
      res_stb_q <= raw_stb_q && !clear_pipe;
      if (raw_stb_q) begin
        res_q <= adf_sat(cal_prod >>> FSC_SHIFT);
      end
    end
  end
  assign O_RDATA        = rdata_q;
  assign O_RESULT       = res_q;
  assign O_RESULT_VALID = res_stb_q;
  assign O_POS_SEL      = mux_q[MUX_POS_LSB +: 4];
  assign O_NEG_SEL      = mux_q[3:0];
  assign O_GAIN_CODE    = cfg_q[CFG_GAIN_LSB +: 3];
  assign O_PGA_BYPASS   = bypass_q;
  assign O_REF_SEL      = cfg_q[CFG_REF_LSB +: 3];
  assign O_RATE_CODE    = cfg_q[CFG_RATE_LSB +: 2];
  assign O_RUNNING      = running_q;

  // checking helpers
  logic [7:0] h_gap_q;
  logic       h_seen_q;
  logic [9:0] h_smp_q;
  logic [3:0] h_avg_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      h_gap_q  <= 8'h00;
      h_seen_q <= 1'b0;
    end else begin
      h_gap_q  <= mod_stb_q ? 8'h00 : h_gap_q + 8'h01;
      h_seen_q <= h_seen_q | mod_stb_q;
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N || clear_pipe || cic_stb_q) begin
      h_smp_q <= 10'h000;
    end else if (mod_stb_q) begin
      h_smp_q <= h_smp_q + 10'h001;
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N || clear_pipe || raw_stb_q) begin
      h_avg_q <= 4'h0;
    end else if (take) begin
      h_avg_q <= h_avg_q + 4'h1;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  sample_spacing_a: assert property ((mod_stb_q && h_seen_q) |-> h_gap_q == MOD_DIV_LAST)
    else $error("modulator samples not 144 clocks apart");
  sinc3_ratio_a: assert property (cic_stb_q
    |-> h_smp_q == {1'b0, adf_dec_last(rate)} + 10'h001)
    else $error("first stage ratio wrong");
  sinc1_ten_a: assert property ((raw_stb_q && rate == RATE_10)
    |-> h_avg_q == AVG_LAST + 4'h1)
    else $error("second stage did not average ten");
  stage_bypass_a: assert property ((take && rate != RATE_10 && !clear_pipe)
    |=> raw_stb_q && raw_q == $past(s1_q))
    else $error("bypass did not pass first stage result");
  result_follow_a: assert property ((raw_stb_q && !clear_pipe) |=> O_RESULT_VALID)
    else $error("result strobe missing");
  valid_pulse_a: assert property (O_RESULT_VALID |=> !O_RESULT_VALID)
    else $error("valid longer than one cycle");
  pga_bypass_a: assert property (O_PGA_BYPASS == (O_GAIN_CODE < GAIN_PGA_MIN))
    else $error("amplifier bypass disagrees with gain");
  mux_write_a: assert property (wr_mux |=> {O_POS_SEL, O_NEG_SEL} == $past(I_WDATA))
    else $error("input select not stored");
  ref_legal_a: assert property (O_REF_SEL <= REF_SUPPLY)
    else $error("reference code out of range");
  begin_cmd_a: assert property ((cmd_begin && !cmd_halt) |=> O_RUNNING ##1 !O_RESULT_VALID)
    else $error("begin did not start conversions");
  halt_cmd_a: assert property (cmd_halt |=> !O_RUNNING && !O_RESULT_VALID)
    else $error("halt did not stop conversions");

endmodule : adf_filter

//--- verilog/adf_pkg.sv
// constants and types for the auxiliary converter decimation filter
package adf_pkg;

  // register byte addresses
  localparam logic [7:0]  ADDR_CFG       = 8'h15;
  localparam logic [7:0]  ADDR_MUX       = 8'h16;
  localparam logic [7:0]  ADDR_OFS_LO    = 8'h17;
  localparam logic [7:0]  ADDR_OFS_HI    = 8'h18;
  localparam logic [7:0]  ADDR_FSC_LO    = 8'h19;
  localparam logic [7:0]  ADDR_FSC_HI    = 8'h1a;
  localparam logic [7:0]  ADDR_RES_LO    = 8'h1b;
  localparam logic [7:0]  ADDR_RES_MID   = 8'h1c;
  localparam logic [7:0]  ADDR_RES_HI    = 8'h1d;
  localparam logic [7:0]  ADDR_STATUS    = 8'h1e;

  // reset values
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  MUX_RESET      = 8'h01;
  localparam logic [15:0] OFS_RESET      = 16'h0000;
  localparam logic [15:0] FSC_RESET      = 16'h4000;

  // config register fields
  localparam int          CFG_GAIN_LSB   = 0;
  localparam int          CFG_REF_LSB    = 3;
  localparam int          CFG_RATE_LSB   = 6;
  localparam int          MUX_POS_LSB    = 4;

  // rate codes
  localparam logic [1:0]  RATE_10        = 2'h0;
  localparam logic [1:0]  RATE_100       = 2'h1;
  localparam logic [1:0]  RATE_400       = 2'h2;
  localparam logic [1:0]  RATE_800       = 2'h3;

  // reference codes
  localparam logic [2:0]  REF_INT        = 3'h0;
  localparam logic [2:0]  REF_P01        = 3'h1;
  localparam logic [2:0]  REF_P23        = 3'h2;
  localparam logic [2:0]  REF_P45        = 3'h3;
  localparam logic [2:0]  REF_SUPPLY     = 3'h4;

  // first gain code that uses the amplifier
  localparam logic [2:0]  GAIN_PGA_MIN   = 3'h3;

  // modulator sample divider: 144 clocks, count 0..143
  localparam logic [7:0]  MOD_DIV_LAST   = 8'h8f;

  // first stage ratio minus one: 512, 128, 64
  localparam logic [8:0]  DEC_512_LAST   = 9'h1ff;
  localparam logic [8:0]  DEC_128_LAST   = 9'h07f;
  localparam logic [8:0]  DEC_64_LAST    = 9'h03f;

  // first stage gain alignment to 24 bits
  localparam int          SH_512_RIGHT   = 4;
  localparam int          SH_128_LEFT    = 2;
  localparam int          SH_64_LEFT     = 5;

  // second stage: ten outputs averaged, reciprocal of ten in q0.24
  localparam logic [3:0]  AVG_LAST       = 4'h9;
  localparam logic [21:0] AVG_RECIP      = 22'h19_999a;
  localparam int          AVG_SHIFT      = 24;

  // unsettled first stage outputs dropped after a restart
  localparam logic [1:0]  SETTLE_LAST    = 2'h1;

  // calibration alignment
  localparam int          OFS_SHIFT      = 8;
  localparam int          FSC_SHIFT      = 14;

  // command opcodes with the low bit ignored (0ch/0dh and 0eh/0fh)
  localparam logic [6:0]  CMD_BEGIN_HI   = 7'h06;
  localparam logic [6:0]  CMD_HALT_HI    = 7'h07;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_RUN
  } adf_state_t;

endpackage : adf_pkg

//--- bench/adf_mod_model.sv
// modulator bitstream source standing in for the analog front end
`timescale 1ns/1ps
module adf_mod_model (
  input  wire logic i_clk,
  input  wire logic i_ones,
  output logic      o_bit
);
  // constant density stream: all ones or all zeros
  always @(posedge i_clk) begin
    o_bit <= i_ones;
  end
endmodule : adf_mod_model

//--- bench/adf_filter_tb_top.sv
// self-checking bench for the auxiliary converter filter
`timescale 1ns/1ps
module adf_filter_tb_top
  import adf_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
  } adf_row_t;

  logic        clk;
  logic        rst_n;
  logic        mod_bit;
  logic        mod_ones;
  logic        cmd_valid;
  logic [7:0]  cmd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  rdata;
  logic [23:0] result;
  logic        res_valid;
  logic [3:0]  pos;
  logic [3:0]  neg;
  logic [2:0]  gain;
  logic        bypass;
  logic [2:0]  refsel;
  logic [1:0]  rate;
  logic        running;
  int          fails;
  int          n_compared;
  adf_row_t    rows[8];

  adf_filter uut (
    .I_CORE_CLK    (clk),
    .I_RST_N       (rst_n),
    .I_MOD_BIT     (mod_bit),
    .I_CMD_VALID   (cmd_valid),
    .I_CMD         (cmd),
    .I_ADDR        (addr),
    .I_WDATA       (wdata),
    .I_WR          (wr_s),
    .I_RD          (rd_s),
    .O_RDATA       (rdata),
    .O_RESULT      (result),
    .O_RESULT_VALID(res_valid),
    .O_POS_SEL     (pos),
    .O_NEG_SEL     (neg),
    .O_GAIN_CODE   (gain),
    .O_PGA_BYPASS  (bypass),
    .O_REF_SEL     (refsel),
    .O_RATE_CODE   (rate),
    .O_RUNNING     (running)
  );

  adf_mod_model modsrc (
    .i_clk (clk),
    .i_ones(mod_ones),
    .o_bit (mod_bit)
  );

  always #4 clk = ~clk;

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("read data", {16'h0000, rdata}, {16'h0000, exp});
    @(posedge clk);
    #1;
    chk("read data idle", {16'h0000, rdata}, 24'h00_0000);
  endtask : reg_rd

  task automatic send_cmd(input logic [7:0] op);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= op;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask : send_cmd

  task automatic wait_valid(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (res_valid !== 1'b1 && n < lim);
    if (res_valid !== 1'b1) begin
      fails++;
      $display("Error result_valid expected 1 seen %b", res_valid);
      end_of_test();
    end
  endtask : wait_valid

  initial begin
    int n;
    int k;
    logic [2:0] rexp;
    logic [7:0] ops[6];
    logic       runs[6];
    clk = 1'b0; rst_n = 1'b0; mod_ones = 1'b1; cmd_valid = 1'b0; cmd = 8'h00;
    addr = 8'h00; wdata = 8'h00; wr_s = 1'b0; rd_s = 1'b0;
    fails = 0; n_compared = 0;
    rows = '{'{ADDR_MUX, 8'ha5, 8'ha5}, '{ADDR_OFS_LO, 8'h12, 8'h12},
             '{ADDR_OFS_HI, 8'h34, 8'h34}, '{ADDR_RES_LO, 8'h55, 8'h00},
             '{ADDR_STATUS, 8'hff, 8'h00}, '{8'h40, 8'h77, 8'h00},
             '{ADDR_OFS_LO, 8'h00, 8'h00}, '{ADDR_OFS_HI, 8'h00, 8'h00}};
    ops  = '{8'h0c, 8'h0e, 8'h0d, 8'h0f, 8'h08, 8'h0a};
    runs = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("neg sel", {20'h0_0000, neg}, 24'h00_0001);
    chk("pos sel", {20'h0_0000, pos}, 24'h00_0000);
    chk("bypass", {23'h00_0000, bypass}, 24'h00_0001);
    chk("rate", {22'h00_0000, rate}, 24'h00_0000);
    chk("running", {23'h00_0000, running}, 24'h00_0000);
    reg_rd(ADDR_CFG, CFG_RESET);
    reg_rd(ADDR_MUX, MUX_RESET);
    reg_rd(ADDR_FSC_HI, FSC_RESET[15:8]);
    $display("test reset done");
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a, rows[i].q);
    end
    reg_wr(ADDR_MUX, 8'ha5);
    chk("pos sel", {20'h0_0000, pos}, 24'h00_000a);
    chk("neg sel", {20'h0_0000, neg}, 24'h00_0005);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      rexp = (i < 5) ? 3'(i) : 3'h0;
      reg_wr(ADDR_CFG, {2'(i), 3'(i), 3'(i)});
      chk("gain", {21'h00_0000, gain}, 24'(i));
      chk("bypass", {23'h00_0000, bypass}, {23'h00_0000, i < 3});
      chk("ref sel", {21'h00_0000, refsel}, {21'h00_0000, rexp});
      chk("rate", {22'h00_0000, rate}, 24'(i % 4));
      reg_rd(ADDR_CFG, {2'(i), rexp, 3'(i)});
    end
    $display("test config codes done");
    for (int i = 0; i < 6; i++) begin
      send_cmd(ops[i]);
      chk("running", {23'h00_0000, running}, {23'h00_0000, runs[i]});
    end
    $display("test commands done");
    reg_wr(ADDR_CFG, {RATE_800, REF_INT, 3'h0});
    send_cmd(8'h0c);
    reg_rd(ADDR_STATUS, 8'h01);
    wait_valid(40000, n);
    chk("full scale", result, 24'h7f_ffff);
    wait_valid(20000, n);
    chk("result period", 24'(n), 24'(64 * 144));
    chk("full scale", result, 24'h7f_ffff);
    @(posedge clk);
    #1;
    chk("valid width", {23'h00_0000, res_valid}, 24'h00_0000);
    reg_rd(ADDR_RES_HI, 8'h7f);
    reg_rd(ADDR_RES_MID, 8'hff);
    reg_rd(ADDR_RES_LO, 8'hff);
    $display("test full scale done");
    send_cmd(8'h0f);
    k = 0;
    repeat (12000) begin
      @(posedge clk);
      #1;
      if (res_valid === 1'b1) k++;
    end
    chk("results after halt", 24'(k), 24'h00_0000);
    $display("test halt done");
    @(posedge clk);
    mod_ones <= 1'b0;
    reg_wr(ADDR_FSC_HI, 8'h20);
    send_cmd(8'h0d);
    wait_valid(40000, n);
    chk("half scale negative", result, 24'hc0_0000);
    reg_rd(ADDR_RES_HI, 8'hc0);
    $display("test calibration done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("result", result, 24'h00_0000);
    chk("running", {23'h00_0000, running}, 24'h00_0000);
    chk("pos sel", {20'h0_0000, pos}, 24'h00_0000);
    chk("neg sel", {20'h0_0000, neg}, 24'h00_0001);
    reg_rd(ADDR_FSC_HI, FSC_RESET[15:8]);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : adf_filter_tb_top
